// ===== pkg/ps2h_pkg.sv
// constants, register map and state type for the two-wire keyboard/mouse host
package ps2h_pkg;
   // register index map (word addresses on the plain register port)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_RXDATA = 4'h2;
   localparam logic [3:0] ADDR_TXDATA = 4'h3;
   localparam logic [3:0] ADDR_KEY    = 4'h4;
   localparam logic [3:0] ADDR_KEYF   = 4'h5;
   localparam logic [3:0] ADDR_MSTAT  = 4'h6;
   localparam logic [3:0] ADDR_MX     = 4'h7;
   localparam logic [3:0] ADDR_MY     = 4'h8;
   localparam logic [3:0] ADDR_MFLAG  = 4'h9;
   localparam logic [3:0] ADDR_LEDS   = 4'hA;
   localparam logic [3:0] ADDR_RATE   = 4'hB;
   // control bits
   localparam int CTRL_INHIBIT = 0;
   localparam int CTRL_MOUSE   = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   // status bits
   localparam int ST_RXV   = 0;
   localparam int ST_FERR  = 1;
   localparam int ST_PERR  = 2;
   localparam int ST_BUSY  = 3;
   localparam int ST_KEYV  = 4;
   localparam int ST_MOUSV = 5;
   localparam int ST_TXERR = 6;
   // mouse status byte fields
   localparam int MS_LEFT           = 0;
   localparam int MS_RIGHT          = 1;
   localparam int MS_X_SIGN_BIT     = 4;
   localparam int MS_Y_SIGN_BIT     = 5;
   localparam int MS_X_OVERFLOW_BIT = 6;
   localparam int MS_Y_OVERFLOW_BIT = 7;
   // link bytes
   localparam logic [7:0] CODE_BREAK = 8'hF0;
   localparam logic [7:0] CODE_EXT   = 8'hE0;
   localparam logic [7:0] CODE_ACK   = 8'hFA;
   localparam logic [7:0] CMD_LEDS   = 8'hED;
   localparam logic [7:0] CMD_RATE   = 8'hF3;
   localparam logic [2:0] LED_MASK   = 3'h7;
   // timing
   localparam int CLK_MHZ   = 50;
   localparam int RTS_US    = 100;
   localparam int RX_TO_US  = 200;
   localparam int TX_TO_US  = 20000;
   localparam int TMR_W     = 20;
   localparam int FRAME_LST = 9;
   // link states, one-hot
   typedef enum logic [4:0] {
      LK_IDLE = 5'b00001,
      LK_RX   = 5'b00010,
      LK_RTS  = 5'b00100,
      LK_TX   = 5'b01000,
      LK_ACK  = 5'b10000
   } ps2h_link_t;
endpackage

// ===== verif/ps2h_dev_model.sv
// behavioural keyboard on the two-wire link
`timescale 1ns/100ps
module ps2h_dev_model (
   // resolved lines
   input wire logic clkLine,
   input wire logic datLine,
   // pulls, 1 = pull line low
   output logic     clkPull,
   output logic     datPull
);
   logic [7:0] lastTx;   // last byte sent, for resend
   logic [7:0] rxLog[$]; // bytes taken from host
   initial begin
      clkPull = 1'b0;
      datPull = 1'b0;
      lastTx  = 8'h00;
   end
   // one frame, 160 ns bit period, clock idles high between frames
   task automatic sendByte(input logic [7:0] b, input logic badPar, input logic badStop);
      logic [10:0] f;
      f = {~badStop, ~^b ^ badPar, b, 1'b0};
      wait (clkLine && datLine);
      lastTx = b;
      for (int i = 0; i < 11; i++) begin
         datPull = ~f[i];
         #80 clkPull = 1'b1;
         #80 clkPull = 1'b0;
      end
      datPull = 1'b0;
      #160;
   endtask
   // host request: clock held low by host, then data low with clock free
   always begin
      logic [7:0] b;
      wait (!clkLine && !clkPull);
      wait (clkLine && !datLine && !datPull);
      #80;
      for (int i = 0; i < 10; i++) begin
         clkPull = 1'b1;
         #80 clkPull = 1'b0;
         #78;
         if (i < 8) begin
            b[i] = datLine;
         end
         #2;
      end
      // acknowledge: data low first so the host sees it settled at the eleventh fall
      datPull = 1'b1;
      #80 clkPull = 1'b1;
      #80 clkPull = 1'b0;
      datPull = 1'b0;
      rxLog.push_back(b);
      #400;
      if (b == 8'hEE) begin
         sendByte(8'hEE, 1'b0, 1'b0);
      end else if (b == 8'hFE) begin
         sendByte(lastTx, 1'b0, 1'b0);
      end else begin
         sendByte(8'hFA, 1'b0, 1'b0);
      end
   end
endmodule

// ===== verif/ps2h_host_monitor.sv
// checker on the host's register port and link pin enables
`timescale 1ns/100ps
module ps2h_host_chk
   import ps2h_pkg::*;
#(
   parameter int RTS_CYC   = RTS_US * CLK_MHZ,
   parameter int RX_TO_CYC = RX_TO_US * CLK_MHZ,
   parameter int TX_TO_CYC = TX_TO_US * CLK_MHZ
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   // link pins
   input wire logic       ps2ClkIn,
   input wire logic       ps2ClkOut,
   input wire logic       ps2ClkOeN,
   input wire logic       ps2DatIn,
   input wire logic       ps2DatOut,
   input wire logic       ps2DatOeN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // lines released and read port quiet right after reset
   a_reset_release: assert property ($fell(srst) |-> ps2ClkOeN && ps2DatOeN && regRdata == 8'h00)
      else $error("lines not released after reset");
   // pins may only be pulled low, never driven high
   a_open_drain: assert property (!ps2ClkOut && !ps2DatOut)
      else $error("pin driven high");
   // host never pulls both lines at once
   a_one_line: assert property (ps2ClkOeN || ps2DatOeN)
      else $error("both lines pulled");
   // read data stands only in the cycle after a read
   a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data outside answer cycle");
   // unmapped indexes read as zero
   a_unmapped_read: assert property (regRd && regAddr > ADDR_RATE |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   // clock pulled low stays low for a request or inhibit
   a_clk_hold: assert property ($fell(ps2ClkOeN) |-> !ps2ClkOeN [*8])
      else $error("clock pull too short");
   // start bit comes with release of the clock line
   a_start_swap: assert property ($fell(ps2DatOeN) && $past(ps2ClkOeN) == 1'b0 |-> $rose(ps2ClkOeN))
      else $error("start bit without clock release");
   // start bit only after the clock was held low
   a_rts_first: assert property ($fell(ps2DatOeN) && $rose(ps2ClkOeN) |-> $past(ps2ClkOeN, 8) == 1'b0)
      else $error("start bit without request to send");
   c_tx_start: cover property ($fell(ps2DatOeN));
   c_inhibit:  cover property ((!ps2ClkOeN && ps2DatOeN) [*8]);
   c_read:     cover property (regRd ##1 regRdata != 8'h00);
endmodule
bind ps2h_host ps2h_host_chk #(.RTS_CYC(RTS_CYC), .RX_TO_CYC(RX_TO_CYC), .TX_TO_CYC(TX_TO_CYC)) ps2h_host_chk_i (
   .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .ps2ClkIn(ps2ClkIn), .ps2ClkOut(ps2ClkOut), .ps2ClkOeN(ps2ClkOeN),
   .ps2DatIn(ps2DatIn), .ps2DatOut(ps2DatOut), .ps2DatOeN(ps2DatOeN));

// ===== verif/tb_ps2h_host.sv
// self-checking bench for the two-wire keyboard/mouse host
`timescale 1ns/100ps
module tb_ps2h_host;
   import ps2h_pkg::*;
   logic       clk, srst, regWr, regRd, ps2ClkOut, ps2ClkOeN, ps2DatOut, ps2DatOeN, devClk, devDat;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata;
   int         fail_count, checks, cyc;
   wire        clkLine = ps2ClkOeN & ~devClk; // pulled up unless a party pulls
   wire        datLine = ps2DatOeN & ~devDat;
   ps2h_host #(.RTS_CYC(20), .RX_TO_CYC(200), .TX_TO_CYC(2000)) ps2h_host_i (
      .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .ps2ClkIn(clkLine), .ps2ClkOut(ps2ClkOut), .ps2ClkOeN(ps2ClkOeN),
      .ps2DatIn(datLine), .ps2DatOut(ps2DatOut), .ps2DatOeN(ps2DatOeN));
   ps2h_dev_model ps2h_dev_model_i (.clkLine(clkLine), .datLine(datLine), .clkPull(devClk), .datPull(devDat));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // register write and read, one-cycle strobes
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input string msg);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp, msg);
   endtask
   task automatic send(input logic [7:0] b, input logic badPar, input logic badStop);
      ps2h_dev_model_i.sendByte(b, badPar, badStop);
      repeat (8) @(posedge clk);
   endtask
   // host sends, then wait for the peripheral to have n bytes and reply
   task automatic txChk(input logic [3:0] a, input logic [7:0] v, input int n, input logic [7:0] exp,
                        input logic [7:0] st);
      wr(a, v);
      for (int i = 0; i < 5000 && ps2h_dev_model_i.rxLog.size() < n; i++) @(posedge clk);
      repeat (400) @(posedge clk);
      chk(ps2h_dev_model_i.rxLog[n - 1], exp, "byte seen by peripheral");
      rdChk(ADDR_STATUS, st, "idle with reply held");
      rdChk(ADDR_RXDATA, ps2h_dev_model_i.lastTx, "reply byte");
   endtask
   task automatic t_keys();
      send(8'h1C, 1'b0, 1'b0);
      rdChk(ADDR_STATUS, 8'h11, "rx and key valid");
      rdChk(ADDR_RXDATA, 8'h1C, "rx byte");
      rdChk(ADDR_KEY, 8'h1C, "make code");
      rdChk(ADDR_KEYF, 8'h00, "make flags");
      send(CODE_BREAK, 1'b0, 1'b0);
      send(8'h1C, 1'b0, 1'b0);
      rdChk(ADDR_KEYF, 8'h01, "break flags");
      send(CODE_EXT, 1'b0, 1'b0);
      send(CODE_BREAK, 1'b0, 1'b0);
      send(8'h74, 1'b0, 1'b0);
      rdChk(ADDR_KEY, 8'h74, "extended code");
      rdChk(ADDR_KEYF, 8'h03, "extended break flags");
      rdChk(ADDR_RXDATA, 8'h74, "clear rx valid");
   endtask
   task automatic t_errors();
      send(8'h55, 1'b1, 1'b0);
      rdChk(ADDR_STATUS, 8'h04, "parity error");
      wr(ADDR_STATUS, 8'h46);
      send(8'h55, 1'b0, 1'b1);
      rdChk(ADDR_STATUS, 8'h02, "frame error");
      wr(ADDR_STATUS, 8'h46);
      rdChk(ADDR_STATUS, 8'h00, "errors cleared");
      rdChk(ADDR_RXDATA, 8'h74, "bad bytes dropped");
   endtask
   task automatic t_mouse();
      wr(ADDR_CTRL, 8'h02);
      send(8'h72, 1'b0, 1'b0);
      send(8'hC0, 1'b0, 1'b0);
      send(8'h9C, 1'b0, 1'b0);
      rdChk(ADDR_MSTAT, 8'h72, "mouse status");
      rdChk(ADDR_MFLAG, 8'h1E, "buttons signs overflow");
      rdChk(ADDR_MX, 8'hC0, "x movement");
      rdChk(ADDR_MY, 8'h9C, "y movement");
      send(8'h08, 1'b0, 1'b0);
      send(8'h05, 1'b0, 1'b0);
      send(8'h03, 1'b0, 1'b0);
      rdChk(ADDR_STATUS, 8'h21, "repeated report valid");
      rdChk(ADDR_MX, 8'h05, "repeated x movement");
      rdChk(ADDR_MY, 8'h03, "repeated y movement");
      wr(ADDR_CTRL, 8'h00);
      rdChk(ADDR_RXDATA, 8'h03, "clear rx valid");
   endtask
   task automatic t_inhibit();
      wr(ADDR_CTRL, 8'h01);
      // let the clock pull reach the line before the peripheral looks at it
      repeat (4) @(posedge clk);
      fork
         send(8'h2B, 1'b0, 1'b0);
         begin
            repeat (60) @(posedge clk);
            chk({6'h0, ps2ClkOeN, devDat}, 8'h00, "clock held, peripheral waits");
            wr(ADDR_CTRL, 8'h00);
         end
      join
      rdChk(ADDR_KEY, 8'h2B, "key after release");
      rdChk(ADDR_RXDATA, 8'h2B, "clear rx valid");
   endtask
   task automatic t_cmds();
      txChk(ADDR_LEDS, 8'hFD, 1, CMD_LEDS, 8'h01);
      chk(ps2h_dev_model_i.rxLog[1], 8'h05, "led byte masked");
      txChk(ADDR_RATE, 8'h2A, 3, CMD_RATE, 8'h01);
      chk(ps2h_dev_model_i.rxLog[3], 8'h2A, "rate byte");
      txChk(ADDR_TXDATA, 8'hEE, 5, 8'hEE, 8'h11);
      txChk(ADDR_TXDATA, 8'hFE, 6, 8'hFE, 8'h11);
      txChk(ADDR_TXDATA, 8'hFF, 7, 8'hFF, 8'h11);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      srst       = 1'b1;
      regWr      = 1'b0;
      regRd      = 1'b0;
      regAddr    = 4'h0;
      regWdata   = 8'h00;
      fail_count = 0;
      checks     = 0;
      cyc        = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1 chk({6'h0, ps2ClkOeN, ps2DatOeN}, 8'h03, "lines idle");
      rdChk(ADDR_STATUS, 8'h00, "status after reset");
      rdChk(4'hF, 8'h00, "unmapped index");
      t_keys();
      t_errors();
      t_mouse();
      t_inhibit();
      t_cmds();
      finish_test();
   end
endmodule

// ===== verilog/ps2h_host.sv
// two-wire keyboard/mouse host: link receiver, transmitter, decoder and registers
// How it works
// - both lines released high when no transfer and inhibit is clear
// - frame: start, eight data LSB first, parity, stop
// - eleven clock edges, bits taken on falling edge
// - host holding clock low inhibits peripheral
// - lines driven only by open-drain pull-downs
// - ED, acknowledge FA, then LED byte
// - F3, acknowledge, then repeat rate byte
`timescale 1ns/100ps
module ps2h_host
   import ps2h_pkg::*;
#(
   parameter int RTS_CYC   = RTS_US * CLK_MHZ,
   parameter int RX_TO_CYC = RX_TO_US * CLK_MHZ,
   parameter int TX_TO_CYC = TX_TO_US * CLK_MHZ
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdata,
   // link clock pin
   input  wire logic       ps2ClkIn,
   output logic            ps2ClkOut,
   output logic            ps2ClkOeN,
   // link data pin
   input  wire logic       ps2DatIn,
   output logic            ps2DatOut,
   output logic            ps2DatOeN
);
   // timer limits at counter width
   localparam logic [TMR_W-1:0] RTS_LIM = TMR_W'(RTS_CYC - 1);
   localparam logic [TMR_W-1:0] RXT_LIM = TMR_W'(RX_TO_CYC - 1);
   localparam logic [TMR_W-1:0] TXT_LIM = TMR_W'(TX_TO_CYC - 1);

   // input synchronisers and filtered levels
   logic [2:0]       clkSync_ff;   // link clock, three stages
   logic [2:0]       datSync_ff;   // link data, three stages
   logic             clkLvl_ff;    // accepted clock level
   logic             datLvl_ff;    // accepted data level
   logic             nxt_clkLvl;
   logic             nxt_datLvl;
   logic             linkFall;     // accepted falling edge of link clock

   // link engine state
   ps2h_link_t       st_ff, nxt_st;
   logic [TMR_W-1:0] tmr_ff, nxt_tmr;        // watchdog / request timer
   logic [3:0]       bitCnt_ff, nxt_bitCnt;  // bit position in frame
   logic [9:0]       rxShift_ff, nxt_rxShift;
   logic [9:0]       txShift_ff, nxt_txShift;
   logic             clkOeN_ff, nxt_clkOeN;
   logic             datOeN_ff, nxt_datOeN;
   logic [9:0]       rxWord;                 // frame with newest bit shifted in

   // software visible state
   logic [1:0]       ctrl_ff, nxt_ctrl;
   logic             rxValid_ff, nxt_rxValid;
   logic             frameErr_ff, nxt_frameErr;
   logic             parErr_ff, nxt_parErr;
   logic             txErr_ff, nxt_txErr;
   logic [7:0]       rxData_ff, nxt_rxData;
   logic             txReq_ff, nxt_txReq;    // byte waiting to go out
   logic [7:0]       txByte_ff, nxt_txByte;
   logic             pend2_ff, nxt_pend2;    // second command byte waits for ack
   logic [7:0]       second_ff, nxt_second;
   logic [2:0]       leds_ff, nxt_leds;
   logic [7:0]       rate_ff, nxt_rate;

   // decoder state
   logic             brk_ff, nxt_brk;        // break prefix seen
   logic             ext_ff, nxt_ext;        // extended prefix seen
   logic [7:0]       key_ff, nxt_key;
   logic [1:0]       keyFlag_ff, nxt_keyFlag;
   logic             keyValid_ff, nxt_keyValid;
   logic [1:0]       mIdx_ff, nxt_mIdx;      // word index in mouse packet
   logic [7:0]       mStat_ff, nxt_mStat;
   logic [7:0]       mX_ff, nxt_mX;
   logic [7:0]       mY_ff, nxt_mY;
   logic             mValid_ff, nxt_mValid;
   logic [7:0]       rdata_ff, nxt_rdata;

   // misc
   logic             busy;
   logic             ok;
   logic [7:0]       b;
   logic [7:0]       mFlags;

   // synchroniser: first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         clkSync_ff <= 3'h7;
         datSync_ff <= 3'h7;
      end else begin
         clkSync_ff <= {clkSync_ff[1:0], ps2ClkIn};
         datSync_ff <= {datSync_ff[1:0], ps2DatIn};
      end
   end

   // a level counts once the second and third stages agree
   always_comb begin
      nxt_clkLvl = (clkSync_ff[1] == clkSync_ff[2]) ? clkSync_ff[2] : clkLvl_ff;
      nxt_datLvl = (datSync_ff[1] == datSync_ff[2]) ? datSync_ff[2] : datLvl_ff;
   end

   // bits are taken on the accepted falling edge
   assign linkFall = clkLvl_ff & ~nxt_clkLvl;
   assign rxWord   = {datLvl_ff, rxShift_ff[9:1]};
   assign busy     = txReq_ff | pend2_ff | (st_ff != LK_IDLE);

   // decoded mouse flags from the status byte
   assign mFlags = {2'h0, mStat_ff[MS_Y_OVERFLOW_BIT], mStat_ff[MS_X_OVERFLOW_BIT],
                    mStat_ff[MS_Y_SIGN_BIT], mStat_ff[MS_X_SIGN_BIT],
                    mStat_ff[MS_RIGHT], mStat_ff[MS_LEFT]};

   // next state: register access first so hardware sets win over clears
   always_comb begin
      nxt_st = st_ff;           nxt_tmr = tmr_ff + TMR_W'(1);
      nxt_bitCnt = bitCnt_ff;   nxt_rxShift = rxShift_ff;
      nxt_txShift = txShift_ff; nxt_clkOeN = clkOeN_ff;
      nxt_datOeN = datOeN_ff;   nxt_ctrl = ctrl_ff;
      nxt_rxValid = rxValid_ff; nxt_frameErr = frameErr_ff;
      nxt_parErr = parErr_ff;   nxt_txErr = txErr_ff;
      nxt_rxData = rxData_ff;   nxt_txReq = txReq_ff;
      nxt_txByte = txByte_ff;   nxt_pend2 = pend2_ff;
      nxt_second = second_ff;   nxt_leds = leds_ff;
      nxt_rate = rate_ff;       nxt_brk = brk_ff;
      nxt_ext = ext_ff;         nxt_key = key_ff;
      nxt_keyFlag = keyFlag_ff; nxt_keyValid = keyValid_ff;
      nxt_mIdx = mIdx_ff;       nxt_mStat = mStat_ff;
      nxt_mX = mX_ff;           nxt_mY = mY_ff;
      nxt_mValid = mValid_ff;   nxt_rdata = 8'h00;
      ok = 1'b0;
      b  = rxWord[7:0];

      // read data stands for one cycle only; some reads clear flags
      if (regRd) begin
         unique case (regAddr)
            ADDR_CTRL:   nxt_rdata = {6'h00, ctrl_ff};
            ADDR_STATUS: nxt_rdata = {1'b0, txErr_ff, mValid_ff, keyValid_ff, busy,
                                      parErr_ff, frameErr_ff, rxValid_ff};
            ADDR_RXDATA: begin
               nxt_rdata   = rxData_ff;
               nxt_rxValid = 1'b0;
            end
            ADDR_KEY: begin
               nxt_rdata    = key_ff;
               nxt_keyValid = 1'b0;
            end
            ADDR_KEYF:   nxt_rdata = {6'h00, keyFlag_ff};
            ADDR_MSTAT:  nxt_rdata = mStat_ff;
            ADDR_MX:     nxt_rdata = mX_ff;
            ADDR_MY: begin
               nxt_rdata  = mY_ff;
               nxt_mValid = 1'b0;
            end
            ADDR_MFLAG:  nxt_rdata = mFlags;
            ADDR_LEDS:   nxt_rdata = {5'h00, leds_ff};
            ADDR_RATE:   nxt_rdata = rate_ff;
            default:     nxt_rdata = 8'h00;
         endcase
      end

      // writes; command writes are dropped while a transfer is pending
      if (regWr) begin
         unique case (regAddr)
            ADDR_CTRL: begin
               nxt_ctrl = regWdata[1:0];
               nxt_mIdx = 2'h0;
            end
            ADDR_STATUS: begin
               if (regWdata[ST_FERR])  nxt_frameErr = 1'b0;
               if (regWdata[ST_PERR])  nxt_parErr = 1'b0;
               if (regWdata[ST_TXERR]) nxt_txErr = 1'b0;
            end
            ADDR_TXDATA: if (!busy) begin
               nxt_txByte = regWdata;
               nxt_txReq  = 1'b1;
            end
            ADDR_LEDS: if (!busy) begin
               nxt_leds   = regWdata[2:0] & LED_MASK;
               nxt_txByte = CMD_LEDS;
               nxt_txReq  = 1'b1;
               nxt_second = {5'h00, regWdata[2:0] & LED_MASK};
               nxt_pend2  = 1'b1;
            end
            ADDR_RATE: if (!busy) begin
               nxt_rate   = regWdata;
               nxt_txByte = CMD_RATE;
               nxt_txReq  = 1'b1;
               nxt_second = regWdata;
               nxt_pend2  = 1'b1;
            end
            default: ;
         endcase
      end

      // link engine
      unique case (st_ff)
         LK_IDLE: begin
            nxt_tmr    = '0;
            nxt_clkOeN = ~ctrl_ff[CTRL_INHIBIT];
            nxt_datOeN = 1'b1;
            if (txReq_ff && !ctrl_ff[CTRL_INHIBIT]) begin
               nxt_st      = LK_RTS;
               nxt_clkOeN  = 1'b0;
               nxt_txShift = {1'b1, ~^txByte_ff, txByte_ff};
               nxt_txReq   = 1'b0;
               nxt_bitCnt  = 4'h0;
            end else if (linkFall && !datLvl_ff && !ctrl_ff[CTRL_INHIBIT]) begin
               nxt_st      = LK_RX;                     // start bit seen
               nxt_bitCnt  = 4'h0;
            end
         end
         LK_RX: begin
            if (linkFall) begin
               nxt_tmr     = '0;
               nxt_rxShift = rxWord;                    // LSB first
               nxt_bitCnt  = bitCnt_ff + 4'h1;
               if (bitCnt_ff == 4'(FRAME_LST)) begin
                  nxt_st = LK_IDLE;
                  if (!rxWord[9]) begin
                     nxt_frameErr = 1'b1;
                  end else if (!(^rxWord[8:0])) begin
                     nxt_parErr = 1'b1;
                  end else begin
                     ok = 1'b1;
                  end
               end
            end else if (tmr_ff == RXT_LIM) begin
               nxt_frameErr = 1'b1;                     // stalled frame
               nxt_st       = LK_IDLE;
            end
         end
         LK_RTS: begin
            // clock held low before start bit is placed
            if (tmr_ff == RTS_LIM) begin
               nxt_tmr    = '0;
               nxt_datOeN = 1'b0;                       // start bit
               nxt_clkOeN = 1'b1;
               nxt_st     = LK_TX;
            end
         end
         LK_TX: begin
            if (linkFall) begin
               nxt_tmr    = '0;
               nxt_datOeN = txShift_ff[bitCnt_ff];
               nxt_bitCnt = bitCnt_ff + 4'h1;
               if (bitCnt_ff == 4'(FRAME_LST)) nxt_st = LK_ACK;
            end else if (tmr_ff == TXT_LIM) begin
               nxt_txErr  = 1'b1;
               nxt_pend2  = 1'b0;
               nxt_datOeN = 1'b1;
               nxt_st     = LK_IDLE;
            end
         end
         LK_ACK: begin
            // peripheral pulls data low on the eleventh edge
            if (linkFall) begin
               if (datLvl_ff) nxt_txErr = 1'b1;
               nxt_st = LK_IDLE;
            end else if (tmr_ff == TXT_LIM) begin
               nxt_txErr = 1'b1;
               nxt_pend2 = 1'b0;
               nxt_st    = LK_IDLE;
            end
         end
         default: begin
            nxt_st     = LK_IDLE;
            nxt_clkOeN = 1'b1;
            nxt_datOeN = 1'b1;
         end
      endcase

      // byte decoder
      if (ok) begin
         nxt_rxData  = b;
         nxt_rxValid = 1'b1;
         if (pend2_ff && b == CODE_ACK) begin
            nxt_txByte = second_ff;
            nxt_txReq  = 1'b1;
            nxt_pend2  = 1'b0;
         end
         if (ctrl_ff[CTRL_MOUSE]) begin
            // three words form one report
            unique case (mIdx_ff)
               2'h0: nxt_mStat = b;
               2'h1: nxt_mX = b;
               default: begin
                  nxt_mY     = b;
                  nxt_mValid = 1'b1;
               end
            endcase
            nxt_mIdx = (mIdx_ff == 2'h2) ? 2'h0 : mIdx_ff + 2'h1;
         end else if (b == CODE_BREAK) begin
            nxt_brk = 1'b1;
         end else if (b == CODE_EXT) begin
            nxt_ext = 1'b1;
         end else if (b != CODE_ACK) begin
            nxt_key      = b;
            nxt_keyFlag  = {ext_ff, brk_ff};
            nxt_keyValid = 1'b1;
            nxt_brk      = 1'b0;
            nxt_ext      = 1'b0;
         end
      end
   end

   // state registers
   always_ff @(posedge clk) begin
      if (srst) begin
         clkLvl_ff  <= 1'b1;    datLvl_ff   <= 1'b1;
         st_ff      <= LK_IDLE; tmr_ff      <= '0;
         bitCnt_ff  <= 4'h0;    rxShift_ff  <= 10'h000;
         txShift_ff <= 10'h3FF; clkOeN_ff   <= 1'b1;
         datOeN_ff  <= 1'b1;    ctrl_ff     <= CTRL_RST;
         rxValid_ff <= 1'b0;    frameErr_ff <= 1'b0;
         parErr_ff  <= 1'b0;    txErr_ff    <= 1'b0;
         rxData_ff  <= 8'h00;   txReq_ff    <= 1'b0;
         txByte_ff  <= 8'h00;   pend2_ff    <= 1'b0;
         second_ff  <= 8'h00;   leds_ff     <= 3'h0;
         rate_ff    <= 8'h00;   brk_ff      <= 1'b0;
         ext_ff     <= 1'b0;    key_ff      <= 8'h00;
         keyFlag_ff <= 2'h0;    keyValid_ff <= 1'b0;
         mIdx_ff    <= 2'h0;    mStat_ff    <= 8'h00;
         mX_ff      <= 8'h00;   mY_ff       <= 8'h00;
         mValid_ff  <= 1'b0;    rdata_ff    <= 8'h00;
      end else begin
         clkLvl_ff  <= nxt_clkLvl;  datLvl_ff   <= nxt_datLvl;
         st_ff      <= nxt_st;      tmr_ff      <= nxt_tmr;
         bitCnt_ff  <= nxt_bitCnt;  rxShift_ff  <= nxt_rxShift;
         txShift_ff <= nxt_txShift; clkOeN_ff   <= nxt_clkOeN;
         datOeN_ff  <= nxt_datOeN;  ctrl_ff     <= nxt_ctrl;
         rxValid_ff <= nxt_rxValid; frameErr_ff <= nxt_frameErr;
         parErr_ff  <= nxt_parErr;  txErr_ff    <= nxt_txErr;
         rxData_ff  <= nxt_rxData;  txReq_ff    <= nxt_txReq;
         txByte_ff  <= nxt_txByte;  pend2_ff    <= nxt_pend2;
         second_ff  <= nxt_second;  leds_ff     <= nxt_leds;
         rate_ff    <= nxt_rate;    brk_ff      <= nxt_brk;
         ext_ff     <= nxt_ext;     key_ff      <= nxt_key;
         keyFlag_ff <= nxt_keyFlag; keyValid_ff <= nxt_keyValid;
         mIdx_ff    <= nxt_mIdx;    mStat_ff    <= nxt_mStat;
         mX_ff      <= nxt_mX;      mY_ff       <= nxt_mY;
         mValid_ff  <= nxt_mValid;  rdata_ff    <= nxt_rdata;
      end
   end

   // pins only ever pull low; the driven level is a constant zero
   logic pinLow_ff;
   always_ff @(posedge clk) begin
      pinLow_ff <= 1'b0;
   end

   assign regRdata  = rdata_ff;
   assign ps2ClkOut = pinLow_ff;
   assign ps2DatOut = pinLow_ff;
   assign ps2ClkOeN = clkOeN_ff;
   assign ps2DatOeN = datOeN_ff;
endmodule
